// ### logic/smp_pkg.sv
// Purpose: Constants and types for the stepper motion profiler
// Assumes: 40 MHz clock, registers on a plain strobe port
// Notes:   One word per register index
package smp_pkg;
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned TICK_HZ         = 1_000;
   localparam int unsigned TICK_CYC        = CLK_HZ / TICK_HZ;
   localparam int unsigned CALC_TIME_NS    = 20_000;
   localparam int unsigned CALC_CYC        = CALC_TIME_NS / 25;
   localparam int unsigned ADDR_W          = 4;
   localparam logic [3:0] REG_MASTER_CFG  = 4'h0;
   localparam logic [3:0] REG_INPUT_CFG   = 4'h1;
   localparam logic [3:0] REG_ACCEL       = 4'h2;
   localparam logic [3:0] REG_DECEL       = 4'h3;
   localparam logic [3:0] REG_MAX_START   = 4'h4;
   localparam logic [3:0] REG_MAX_STOP    = 4'h5;
   localparam logic [3:0] REG_BACKLASH    = 4'h6;
   localparam logic [3:0] REG_TARGET_SPD  = 4'h7;
   localparam logic [3:0] REG_DISP_CMD    = 4'h8;
   localparam logic [3:0] REG_CONTROL     = 4'h9;
   localparam logic [3:0] REG_ABS_POS     = 4'hA;
   localparam logic [3:0] REG_DISP_CNT    = 4'hB;
   localparam logic [3:0] REG_SPEED       = 4'hC;
   localparam logic [3:0] REG_STATUS      = 4'hD;
   localparam int unsigned CFG_ENABLE_BIT  = 10;
   localparam int unsigned ACCEL_MODE_BIT  = 8;
   localparam int unsigned DECEL_MODE_BIT  = 9;
   localparam int unsigned COUNT_POL_BIT   = 0;
   localparam int unsigned CTL_CLR_POS     = 0;
   localparam int unsigned CTL_BL_COMP     = 1;
   localparam int unsigned CTL_DIR         = 2;
   localparam logic [31:0] RATE_MAX        = 32'h03DF_D240;
   localparam logic [31:0] PERIOD_MAX      = 32'h0000_EA60;
   localparam logic [16:0] BACKLASH_RST    = 17'h0_0000;
   typedef enum logic [1:0] {
      SMP_IDLE  = 2'b00,
      SMP_ACCEL = 2'b01,
      SMP_COAST = 2'b11,
      SMP_DECEL = 2'b10
   } smp_state_t;
endpackage

// ### logic/smp_divider.sv
// Purpose: Sequential unsigned divider, one quotient bit per cycle
// Assumes: Divisor nonzero when started
// Notes:   Used for period-mode rate and brake-distance work
`timescale 1ns/10ps
`default_nettype none
module smp_divider #(
   parameter int unsigned W = 64
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         start_i,
   input  wire logic [W-1:0] num_i,
   input  wire logic [W-1:0] den_i,
   output logic              done_o,
   output logic [W-1:0]      quo_o
);
   logic [W-1:0] rem, next_rem, den, next_den, quo, next_quo;
   logic [7:0]   cnt, next_cnt;
   logic         busy, next_busy, next_done;
   logic [W:0]   trial;
   if (W < 2 || W > 128) $error("smp_divider width out of range");
   always_comb begin
      next_rem  = rem;
      next_den  = den;
      next_quo  = quo;
      next_cnt  = cnt;
      next_busy = busy;
      next_done = 1'b0;
      trial     = {rem, quo[W-1]} - {1'b0, den};
      if (start_i) begin
         next_rem  = '0;
         next_quo  = num_i;
         next_den  = (den_i == '0) ? {{(W-1){1'b0}}, 1'b1} : den_i;
         next_cnt  = 8'(W);
         next_busy = 1'b1;
      end else if (busy) begin
         if (!trial[W]) begin
            next_rem = trial[W-1:0];
            next_quo = {quo[W-2:0], 1'b1};
         end else begin
            next_rem = {rem[W-2:0], quo[W-1]};
            next_quo = {quo[W-2:0], 1'b0};
         end
         next_cnt = cnt - 8'h01;
         if (cnt == 8'h01) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rem <= '0;
         den <= '0;
         quo <= '0;
         cnt <= '0;
         busy <= 1'b0;
         done_o <= 1'b0;
      end else begin
         rem <= next_rem;
         den <= next_den;
         quo <= next_quo;
         cnt <= next_cnt;
         busy <= next_busy;
         done_o <= next_done;
      end
   end
   assign quo_o = quo;
endmodule
`default_nettype wire

// ### logic/smp_profiler.sv
// Purpose: Speed profile, displacement moves, direction, counters, backlash
// Assumes: Speeds in pulses per second, updated once per 1 ms tick
// Notes:   Step pulses leave as a one-cycle strobe with direction
//
// What this block does
// [R1] Jump to max start speed, then ramp
// [R2] Target under max start: set at once
// [R3] Above max start: linear acceleration only
// [R4] Decelerate uniformly above max stop speed
// [R5] Uniform deceleration then step to target
// [R6] Both under max stop: single step
// [R7] Zero limit forces purely linear ramps
// [R8] Recompute braking point continuously, 64-bit
// [R9] Short moves brake before reaching target
// [R10] Module decides direction; no instant reversal
// [R11] Position counts by direction and polarity
// [R12] Position kept on power fail, cleared explicitly
// [R13] New displacement command clears displacement counter
// [R14] Add backlash pulses at every reversal
// [R15] Backlash 17-bit pulses, resets to zero
// [R16] Config bit 10 enables profile module
// [R17] Accel mode 0: rate 1..65000000
// [R18] Accel mode 1: period 1..60000 ms; the write clamps to 1..65000000 in both modes
// [R19] Decel mode 0: rate 1..65000000
// [R20] Decel mode 1: period 1..60000 ms; the write clamps to 1..65000000 in both modes
// [R21] Start and stop limits in pps
// [R22] Host ensures no backlash at enabling
// [R23] Period mode rate is delta over period
// [R24] Reversal decelerates to zero first
`timescale 1ns/10ps
`default_nettype none
module smp_profiler
   import smp_pkg::*;
#(
   parameter int unsigned SPD_W = 24
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_n_i,
   input  wire logic [smp_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [31:0]             wdata_i,
   input  wire logic                    wr_i,
   input  wire logic                    rd_i,
   input  wire logic                    sensor_clear_i,
   input  wire logic                    power_fail_i,
   input  wire logic [31:0]             restore_pos_i,
   input  wire logic                    restore_i,
   output logic [31:0]                  rdata_o,
   output logic                         step_o,
   output logic                         dir_o,
   output logic [31:0]                  saved_pos_o,
   output logic                         save_o
);
   if (SPD_W < 8 || SPD_W > 31) $error("SPD_W out of range");
   logic [15:0]      master_cfg, next_master_cfg;
   logic             count_pol, next_count_pol;
   logic [31:0]      accel, next_accel, decel, next_decel;
   logic [SPD_W-1:0] max_start, next_max_start, max_stop, next_max_stop;
   logic [16:0]      backlash, next_backlash;
   logic [SPD_W-1:0] target, next_target, speed, next_speed;
   logic             cmd_dir, next_cmd_dir, backlash_on, next_backlash_on;
   logic [31:0]      disp_goal, next_disp_goal, disp_cnt, next_disp_cnt;
   logic             disp_mode, next_disp_mode;
   logic [31:0]      abs_pos, next_abs_pos;
   logic [16:0]      backlash_left, next_backlash_left;
   logic [15:0]      tick_cnt, next_tick_cnt;
   logic [31:0]      phase, next_phase;
   logic [31:0]      rdata_n;
   logic             step_n, dir_n, save_n;
   logic [31:0]      save_n_pos;
   logic             pf_d;
   smp_state_t       state, next_state;
   logic [31:0]      acc_rate, dec_rate;
   logic             tick, move_step;
   logic             div_start, div_done;
   logic [63:0]      div_num, div_den, div_quo;
   logic [63:0]      brake_dist, next_brake_dist;
   logic [31:0]      acc_per, next_acc_per, dec_per, next_dec_per;
   logic [SPD_W-1:0] eff_target, remain_spd;

   assign tick = (tick_cnt == 16'(TICK_CYC - 1));
   // Rate in pulses per s^2 applied per ms tick, hence divide by 1000
   assign acc_rate = master_cfg[ACCEL_MODE_BIT] ? acc_per : accel;  // [R17] [R18]
   assign dec_rate = master_cfg[DECEL_MODE_BIT] ? dec_per : decel;  // [R19] [R20]

   // Divider alternates: period-mode rates, then brake distance v^2/(2a)
   smp_divider #(.W(64)) u_div (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .start_i (div_start),
      .num_i   (div_num),
      .den_i   (div_den),
      .done_o  (div_done),
      .quo_o   (div_quo)
   );
   logic       div_busy, next_div_busy;
   logic [1:0] div_job, next_div_job;
   always_comb begin
      div_start     = 1'b0;
      div_num       = '0;
      div_den       = 64'h1;
      next_div_busy = div_busy;
      next_div_job  = div_job;
      next_acc_per  = acc_per;
      next_dec_per  = dec_per;
      next_brake_dist = brake_dist;
      remain_spd    = (target > speed) ? target - speed : speed - target;
      if (div_done) begin
         next_div_busy = 1'b0;
         case (div_job)
            2'd0: next_acc_per = (div_quo[31:0] == '0) ? 32'h1 : div_quo[31:0];  // [R23]
            2'd1: next_dec_per = (div_quo[31:0] == '0) ? 32'h1 : div_quo[31:0];  // [R23]
            default: next_brake_dist = div_quo;                                  // [R8]
         endcase
      end else if (!div_busy) begin
         div_start     = 1'b1;
         next_div_busy = 1'b1;
         next_div_job  = (div_job == 2'd2) ? 2'd0 : div_job + 2'd1;
         case (next_div_job)
            // Delta speed * 1000 / period_ms gives pulses per s^2
            2'd0: begin
               div_num = 64'(remain_spd) * 64'd1000;
               div_den = {32'h0, accel};
            end
            2'd1: begin
               div_num = 64'(remain_spd) * 64'd1000;
               div_den = {32'h0, decel};
            end
            default: begin
               div_num = 64'(speed) * 64'(speed);      // [R8]
               div_den = {31'h0, dec_rate, 1'b0};
            end
         endcase
      end
   end

   always_comb begin
      next_master_cfg = master_cfg;
      next_count_pol = count_pol;
      next_accel     = accel;
      next_decel     = decel;
      next_max_start = max_start;
      next_max_stop  = max_stop;
      next_backlash  = backlash;
      next_target    = target;
      next_cmd_dir   = cmd_dir;
      next_backlash_on = backlash_on;
      next_disp_goal = disp_goal;
      next_disp_mode = disp_mode;
      rdata_n        = '0;
      if (wr_i) begin
         if (addr_i == REG_MASTER_CFG) begin
            next_master_cfg = wdata_i[15:0];                        // [R16]
         end else if (addr_i == REG_INPUT_CFG) begin
            next_count_pol = wdata_i[COUNT_POL_BIT];
         end else if (addr_i == REG_ACCEL) begin
            next_accel = (wdata_i == '0) ? 32'h1 :
                         (wdata_i > RATE_MAX) ? RATE_MAX : wdata_i; // [R17] [R18]
         end else if (addr_i == REG_DECEL) begin
            next_decel = (wdata_i == '0) ? 32'h1 :
                         (wdata_i > RATE_MAX) ? RATE_MAX : wdata_i; // [R19] [R20]
         end else if (addr_i == REG_MAX_START) begin
            next_max_start = wdata_i[SPD_W-1:0];                   // [R21]
         end else if (addr_i == REG_MAX_STOP) begin
            next_max_stop = wdata_i[SPD_W-1:0];                    // [R21]
         end else if (addr_i == REG_BACKLASH) begin
            next_backlash = (wdata_i > 32'h0001_0000) ? 17'h1_0000 : wdata_i[16:0]; // [R15]
         end else if (addr_i == REG_TARGET_SPD) begin
            next_target = wdata_i[SPD_W-1:0];
            next_disp_mode = 1'b0;
         end else if (addr_i == REG_DISP_CMD) begin
            next_disp_goal = wdata_i;
            next_disp_mode = (wdata_i != '0);
         end else if (addr_i == REG_CONTROL) begin
            next_backlash_on = wdata_i[CTL_BL_COMP];                // [R14]
            next_cmd_dir = wdata_i[CTL_DIR];
         end
      end
      if (rd_i) begin
         if (addr_i == REG_MASTER_CFG) rdata_n = {16'h0, master_cfg};
         else if (addr_i == REG_INPUT_CFG) rdata_n = {31'h0, count_pol};
         else if (addr_i == REG_ACCEL) rdata_n = accel;
         else if (addr_i == REG_DECEL) rdata_n = decel;
         else if (addr_i == REG_MAX_START) rdata_n = 32'(max_start);
         else if (addr_i == REG_MAX_STOP) rdata_n = 32'(max_stop);
         else if (addr_i == REG_BACKLASH) rdata_n = {15'h0, backlash};
         else if (addr_i == REG_TARGET_SPD) rdata_n = 32'(target);
         else if (addr_i == REG_DISP_CMD) rdata_n = disp_goal;
         else if (addr_i == REG_CONTROL) rdata_n = {29'h0, cmd_dir, backlash_on, 1'b0};
         else if (addr_i == REG_ABS_POS) rdata_n = abs_pos;          // [R11]
         else if (addr_i == REG_DISP_CNT) rdata_n = disp_cnt;
         else if (addr_i == REG_SPEED) rdata_n = 32'(speed);
         else if (addr_i == REG_STATUS) rdata_n = {28'h0, dir_o, disp_mode, state};
      end
   end

   // Speed profile, evaluated once per ms tick
   logic [SPD_W-1:0] step_up, step_dn;
   logic [31:0]      up_q, dn_q;
   logic             rev_pending, brake_now;
   logic [31:0]      disp_left;
   always_comb begin
      next_speed    = speed;
      next_state    = state;
      next_tick_cnt = tick ? 16'h0 : tick_cnt + 16'h1;
      dir_n         = dir_o;
      disp_left     = disp_goal - disp_cnt;
      rev_pending   = (cmd_dir != dir_o);                          // [R10]
      brake_now     = disp_mode && ({32'h0, disp_left} <= brake_dist); // [R8] [R9]
      eff_target    = (rev_pending && speed != '0) ? '0 :           // [R24]
                      (disp_mode && disp_left == '0) ? '0 :
                      brake_now ? '0 : target;
      up_q          = acc_rate / 32'(TICK_HZ);
      dn_q          = dec_rate / 32'(TICK_HZ);
      // Rates under one pulse per tick still move, else the ramp stalls
      step_up       = (up_q == 32'h0) ? SPD_W'(1) : SPD_W'(up_q);
      step_dn       = (dn_q == 32'h0) ? SPD_W'(1) : SPD_W'(dn_q);
      if (!master_cfg[CFG_ENABLE_BIT]) begin
         next_speed = target;                                      // [R16]
         dir_n      = cmd_dir;
         next_state = SMP_IDLE;
      end else if (tick) begin
         if (speed == '0 && rev_pending) dir_n = cmd_dir;          // [R10] [R24]
         if (eff_target > speed) begin
            next_state = SMP_ACCEL;
            if (max_start != '0 && speed < max_start) begin       // [R7]
               if (eff_target <= max_start) next_speed = eff_target; // [R2]
               else next_speed = max_start;                        // [R1]
            end else if (eff_target - speed <= step_up) begin
               next_speed = eff_target;                            // [R3]
            end else begin
               next_speed = speed + step_up;                       // [R1] [R3]
            end
         end else if (eff_target < speed) begin
            next_state = SMP_DECEL;
            if (max_stop != '0 && eff_target < max_stop && speed <= max_stop) begin // [R7]
               next_speed = eff_target;                            // [R5] [R6]
            end else if (speed - eff_target <= step_dn) begin
               next_speed = eff_target;                            // [R4]
            end else begin
               next_speed = speed - step_dn;                       // [R4] [R5]
            end
         end else begin
            next_state = (speed == '0) ? SMP_IDLE : SMP_COAST;
         end
      end
   end

   // Pulse generator: phase accumulator at speed pps over CLK_HZ
   always_comb begin
      next_phase = phase + 32'(speed);
      move_step  = 1'b0;
      if (next_phase >= 32'(CLK_HZ)) begin
         next_phase = next_phase - 32'(CLK_HZ);
         move_step  = 1'b1;
      end
   end

   logic dir_prev, next_dir_prev;
   always_comb begin
      next_abs_pos  = abs_pos;
      next_disp_cnt = disp_cnt;
      next_backlash_left = backlash_left;
      next_dir_prev = dir_prev;
      step_n        = 1'b0;
      save_n        = 1'b0;
      save_n_pos    = saved_pos_o;
      if (move_step) begin
         step_n        = 1'b1;
         next_dir_prev = dir_o;
         if (backlash_on && dir_o != dir_prev && backlash != '0) begin
            next_backlash_left = backlash - 17'h1;                 // [R14]
         end else if (backlash_left != '0) begin
            next_backlash_left = backlash_left - 17'h1;            // [R14]
         end else begin
            next_abs_pos  = (dir_o ^ count_pol) ? abs_pos - 32'h1 : abs_pos + 32'h1; // [R11]
            next_disp_cnt = disp_cnt + 32'h1;                      // [R13]
         end
      end
      if (wr_i && addr_i == REG_DISP_CMD) next_disp_cnt = '0;      // [R13]
      if (wr_i && addr_i == REG_CONTROL && wdata_i[CTL_CLR_POS]) next_abs_pos = '0; // [R12]
      if (sensor_clear_i) next_abs_pos = '0;                       // [R12]
      if (restore_i) next_abs_pos = restore_pos_i;                 // [R12]
      if (power_fail_i && !pf_d) begin
         save_n     = 1'b1;                                        // [R12]
         save_n_pos = abs_pos;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         master_cfg <= '0;
         count_pol <= 1'b0;
         accel <= 32'h1;
         decel <= 32'h1;
         max_start <= '0;
         max_stop <= '0;
         backlash <= BACKLASH_RST;
         target <= '0;
         cmd_dir <= 1'b0;
         backlash_on <= 1'b0;
         disp_goal <= '0;
         disp_mode <= 1'b0;
         speed <= '0;
         state <= SMP_IDLE;
         tick_cnt <= '0;
         phase <= '0;
         abs_pos <= '0;
         disp_cnt <= '0;
         backlash_left <= '0;
         dir_prev <= 1'b0;
         div_busy <= 1'b0;
         div_job <= 2'd2;
         acc_per <= 32'h1;
         dec_per <= 32'h1;
         brake_dist <= '0;
         pf_d <= 1'b0;
         rdata_o <= '0;
         step_o <= 1'b0;
         dir_o <= 1'b0;
         saved_pos_o <= '0;
         save_o <= 1'b0;
      end else begin
         master_cfg <= next_master_cfg;
         count_pol <= next_count_pol;
         accel <= next_accel;
         decel <= next_decel;
         max_start <= next_max_start;
         max_stop <= next_max_stop;
         backlash <= next_backlash;
         target <= next_target;
         cmd_dir <= next_cmd_dir;
         backlash_on <= next_backlash_on;
         disp_goal <= next_disp_goal;
         disp_mode <= next_disp_mode;
         speed <= next_speed;
         state <= next_state;
         tick_cnt <= next_tick_cnt;
         phase <= next_phase;
         abs_pos <= next_abs_pos;
         disp_cnt <= next_disp_cnt;
         backlash_left <= next_backlash_left;
         dir_prev <= next_dir_prev;
         div_busy <= next_div_busy;
         div_job <= next_div_job;
         acc_per <= next_acc_per;
         dec_per <= next_dec_per;
         brake_dist <= next_brake_dist;
         pf_d <= power_fail_i;
         rdata_o <= rdata_n;
         step_o <= step_n;
         dir_o <= dir_n;
         saved_pos_o <= save_n_pos;
         save_o <= save_n;
      end
   end
endmodule
`default_nettype wire

// ### sim/smp_motor_model.sv
// Purpose: Motor side model, counts step pulses by direction
// Assumes: One step per high cycle of step_i
// Notes:   Count is what the shaft should show with polarity 0
`timescale 1ns/10ps
`default_nettype none
module smp_motor_model (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        step_i,
   input  wire logic        dir_i,
   output logic [31:0]      pos_o
);
   logic [31:0] next_pos;
   always_comb begin
      next_pos = pos_o;
      if (step_i) begin
         next_pos = dir_i ? pos_o - 32'h1 : pos_o + 32'h1;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pos_o <= 32'h0;
      end else begin
         pos_o <= next_pos;
      end
   end
endmodule
`default_nettype wire

// ### sim/smp_profiler_asserts.sv
// Purpose: Port-level checks of the motion profiler
// Assumes: Single clock domain, reads answer one cycle later
// Notes:   Position checks skip cycles with a step, which moves it
`timescale 1ns/10ps
`default_nettype none
module smp_profiler_asserts
   import smp_pkg::*;
(
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic [smp_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [31:0]                wdata_i,
   input  wire logic                       wr_i,
   input  wire logic                       rd_i,
   input  wire logic                       sensor_clear_i,
   input  wire logic                       power_fail_i,
   input  wire logic [31:0]                restore_pos_i,
   input  wire logic                       restore_i,
   input  wire logic [31:0]                rdata_o,
   input  wire logic                       step_o,
   input  wire logic                       dir_o,
   input  wire logic [31:0]                saved_pos_o,
   input  wire logic                       save_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_clr_wr;
      wr_i && addr_i == REG_CONTROL && wdata_i[CTL_CLR_POS] && !restore_i && !step_o;
   endsequence
   sequence s_sns_clr;
      sensor_clear_i && !restore_i && !step_o;
   endsequence
   sequence s_pos_rd;
      rd_i && addr_i == REG_ABS_POS && !restore_i && !sensor_clear_i && !step_o;
   endsequence
   AST_SAVE: assert property ($rose(power_fail_i) |=> save_o)
      else $error("no save pulse after power fail");
   AST_CLR_POS: assert property (s_clr_wr ##1 s_pos_rd |=> rdata_o == 32'h0)
      else $error("position not cleared by command");
   AST_SNS_CLR: assert property (s_sns_clr ##1 s_pos_rd |=> rdata_o == 32'h0)
      else $error("position not cleared by sensor");
   AST_RESTORE: assert property (restore_i ##1 s_pos_rd |=> rdata_o == $past(restore_pos_i, 2))
      else $error("restored position wrong");
   AST_BACKLASH_RD: assert property ($past(rd_i && addr_i == REG_BACKLASH) |-> rdata_o <= 32'h0001_0000)
      else $error("backlash above limit");
   AST_BACKLASH_WR: assert property (wr_i && addr_i == REG_BACKLASH ##1 rd_i && addr_i == REG_BACKLASH
      |=> rdata_o == (($past(wdata_i, 2) > 32'h0001_0000) ? 32'h0001_0000 : $past(wdata_i, 2)))
      else $error("backlash readback wrong");
   AST_ACC_RD: assert property ($past(rd_i && addr_i == REG_ACCEL) |-> rdata_o inside {[32'h1 : RATE_MAX]})
      else $error("accel out of range");
   AST_DEC_RD: assert property ($past(rd_i && addr_i == REG_DECEL) |-> rdata_o inside {[32'h1 : RATE_MAX]})
      else $error("decel out of range");
   AST_CFG_RB: assert property (wr_i && addr_i == REG_MASTER_CFG ##1 rd_i && addr_i == REG_MASTER_CFG
      |=> rdata_o[CFG_ENABLE_BIT] == $past(wdata_i[CFG_ENABLE_BIT], 2))
      else $error("enable bit readback wrong");
   AST_STEP: assert property (step_o |=> !step_o)
      else $error("step pulse longer than one cycle");
endmodule
bind smp_profiler smp_profiler_asserts u_smp_profiler_asserts (.clk_i, .rst_n_i, .addr_i,
   .wdata_i, .wr_i, .rd_i, .sensor_clear_i, .power_fail_i, .restore_pos_i, .restore_i,
   .rdata_o, .step_o, .dir_o, .saved_pos_o, .save_o);
`default_nettype wire

// ### sim/stepper_motion_profiler_test.sv
// Purpose: Register-level test of the motion profiler
// Assumes: Bus tasks start just after a clock edge
// Notes:   Speed ramps need whole 1 ms ticks, so few are run
`timescale 1ns/10ps
`default_nettype none
module stepper_motion_profiler_test;
   import smp_pkg::*;
   logic clk_i, rst_n_i, wr_i, rd_i, sensor_clear_i, power_fail_i, restore_i;
   logic step_o, dir_o, save_o;
   logic [3:0]  addr_i;
   logic [31:0] wdata_i, restore_pos_i, rdata_o, saved_pos_o, motor_pos, d, sp;
   int n_errors, compares;
   smp_profiler u_smp_profiler (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .sensor_clear_i, .power_fail_i, .restore_pos_i, .restore_i, .rdata_o, .step_o,
      .dir_o, .saved_pos_o, .save_o);
   smp_motor_model u_smp_motor_model (.clk_i, .rst_n_i, .step_i(step_o), .dir_i(dir_o),
      .pos_o(motor_pos));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task end_of_test;
      if (n_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Strobe is raised off the edge and dropped on the edge that takes it
   task wr(input logic [3:0] a, input logic [31:0] v);
      wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task rd(input logic [3:0] a, output logic [31:0] v);
      rd_i <= 1'b1; addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   task pulse_restore;
      restore_i <= 1'b1;
      @(posedge clk_i);
      restore_i <= 1'b0;
      #1;
   endtask
   // One speed step per tick; bound covers a tick plus margin
   task wait_change(input logic [31:0] old, output logic [31:0] v);
      int i;
      v = old;
      for (i = 0; i < 42000 && v === old; i++) rd(REG_SPEED, v);
      if (v === old) begin
         n_errors++;
         end_of_test();
      end
   endtask
   initial begin
      n_errors = 0; compares = 0;
      rst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 4'h0; wdata_i = 32'h0;
      sensor_clear_i = 1'b0; power_fail_i = 1'b0; restore_i = 1'b0;
      restore_pos_i = 32'h0000_1234;
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      #1;
      rd(REG_BACKLASH, d); chk("backlash reset", d, 32'h0);
      rd(REG_ABS_POS, d); chk("position reset", d, 32'h0);
      rd(4'hE, d); chk("unmapped read", d, 32'h0);
      wr(REG_BACKLASH, 32'h0002_0000); rd(REG_BACKLASH, d);
      chk("backlash clamp", d, 32'h0001_0000);
      wr(REG_BACKLASH, 32'h0000_1388); rd(REG_BACKLASH, d);
      chk("backlash value", d, 32'h0000_1388);
      wr(REG_ACCEL, 32'h0); rd(REG_ACCEL, d); chk("accel low", d, 32'h1);
      wr(REG_ACCEL, 32'hFFFF_FFFF); rd(REG_ACCEL, d); chk("accel high", d, RATE_MAX);
      wr(REG_DECEL, 32'h0); rd(REG_DECEL, d); chk("decel low", d, 32'h1);
      wr(REG_DECEL, 32'h03DF_D241); rd(REG_DECEL, d); chk("decel high", d, RATE_MAX);
      wr(REG_MAX_START, 32'h0000_4E20); rd(REG_MAX_START, d);
      chk("max start", d, 32'h0000_4E20);
      wr(REG_MAX_STOP, 32'h0);
      pulse_restore();
      rd(REG_ABS_POS, d); chk("restore", d, 32'h0000_1234);
      power_fail_i <= 1'b1;
      sp = 32'h0;
      repeat (3) begin
         @(posedge clk_i);
         #1 if (save_o === 1'b1) sp = saved_pos_o;
      end
      chk("saved position", sp, 32'h0000_1234);
      power_fail_i <= 1'b0;
      sensor_clear_i <= 1'b1;
      @(posedge clk_i);
      sensor_clear_i <= 1'b0;
      #1 rd(REG_ABS_POS, d); chk("sensor clear", d, 32'h0);
      pulse_restore();
      wr(REG_CONTROL, 32'h0000_0001); rd(REG_ABS_POS, d); chk("command clear", d, 32'h0);
      wr(REG_INPUT_CFG, 32'h0);
      wr(REG_ACCEL, 32'h0000_03E8);
      wr(REG_CONTROL, 32'h0);
      wr(REG_MASTER_CFG, 32'h0000_0400); rd(REG_MASTER_CFG, d);
      chk("enable", d, 32'h0000_0400);
      // Start speed high enough that a tick holds many steps
      wr(REG_TARGET_SPD, 32'h0000_4E84);
      wait_change(32'h0, d); chk("jump to start speed", d, 32'h0000_4E20);
      wait_change(d, d); chk("linear ramp", d, 32'h0000_4E21);
      wr(REG_CONTROL, 32'h0000_0004);
      rd(REG_ABS_POS, d); chk("position count", d, motor_pos);
      chk("steps taken", 32'(motor_pos != 32'h0), 32'h1);
      wr(REG_DISP_CMD, 32'h0000_0010); rd(REG_DISP_CNT, d);
      chk("displacement clear", d, 32'h0);
      chk("no instant reversal", 32'(dir_o), 32'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
